//--- logic/adcsq_conv_timer.sv
/*
  Conversion step timer: a one-cycle pulse every CONV_CYCLES while enabled.
  Assumes a single 100 MHz clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
module adcsq_conv_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_run,
  output logic o_step
);
  localparam logic [7:0] LAST = 8'(adcsq_pkg::CONV_CYCLES - 1);
  logic [7:0] count;

  always_ff @(posedge i_clk) begin
    if (!i_nrst || !i_run) begin
      count <= 8'h00;
    end else if (count == LAST) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  assign o_step = i_run && (count == LAST);
endmodule // adcsq_conv_timer

//--- logic/adcsq_top.sv
/*
  Converter sequence control: byte registers on Avalon-MM, sequencer, status flags and interrupt.
  Assumes a master that holds its request until waitrequest is low; analog conversion is modelled
  by a fixed step time.
*/
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module adcsq_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // avalon-mm slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // converter state
  output logic o_powered,
  output logic o_busy,
  output logic [3:0] o_channel,
  output logic o_conv_step,
  output logic o_justify,
  output logic o_signed,
  // interrupt
  output logic o_irq
);
  logic [7:0] wrap_ctl;
  logic [7:0] trig_ctl;
  logic [7:0] pwr_ctl;
  logic [7:0] seqlen_ctl;
  logic [7:0] timing_ctl;
  logic [7:0] start_ctl;
  logic [7:0] dien_hi;
  logic test1;
  logic sequence_complete_flag;
  logic [3:0] conv_count;
  logic [15:0] ccf;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic ack;
  logic [3:0] seq_len;
  logic [3:0] done_in_seq;
  logic [3:0] chan;
  logic step;
  logic seq_end;
  logic wr_start;
  logic wr_abort;
  logic [7:0] wdata;
  logic [7:0] next_rbyte;
  adcsq_pkg::adcsq_state_e state;

  assign wdata = i_writedata[7:0];
  // one wait cycle per access so the answer always comes from flip-flops
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_read || i_write) && !ack;
    end
  end
  assign o_waitrequest = (i_read || i_write) && !ack;

  logic wr_en;
  assign wr_en = i_write && ack;
  assign wr_start = wr_en && (i_address == adcsq_pkg::REG_START);
  assign wr_abort = wr_en && (i_address == adcsq_pkg::REG_TIMING);

  // configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wrap_ctl <= adcsq_pkg::WRAP_RST;
      trig_ctl <= adcsq_pkg::BYTE_RST;
      seqlen_ctl <= adcsq_pkg::SEQLEN_RST;
      timing_ctl <= adcsq_pkg::TIMING_RST;
      start_ctl <= adcsq_pkg::BYTE_RST;
      dien_hi <= adcsq_pkg::BYTE_RST;
      test1 <= 1'b0;
    end else if (wr_en) begin
      case (i_address)
        adcsq_pkg::REG_WRAP: wrap_ctl <= wdata & adcsq_pkg::WRAP_MASK;
        adcsq_pkg::REG_TRIG: trig_ctl <= wdata & adcsq_pkg::TRIG_MASK;
        adcsq_pkg::REG_SEQLEN: seqlen_ctl <= wdata & adcsq_pkg::SEQLEN_MASK;
        adcsq_pkg::REG_TIMING: timing_ctl <= wdata;
        adcsq_pkg::REG_START: start_ctl <= wdata;
        adcsq_pkg::REG_DIEN_HI: dien_hi <= wdata;
        adcsq_pkg::REG_TEST1: test1 <= wdata[0];
        default: begin
        end
      endcase
    end
  end

  // power and interrupt control; the flag bit mirrors scf and is not stored
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pwr_ctl <= adcsq_pkg::BYTE_RST;
    end else if (wr_en && i_address == adcsq_pkg::REG_PWR) begin
      pwr_ctl <= wdata & adcsq_pkg::PWR_MASK;
    end
  end
  assign o_powered = pwr_ctl[adcsq_pkg::PWR_UP_BIT];

  // sequence length: 0 means 8, as usual for such converters; fifo-less model
  always_comb begin
    seq_len = {1'b0, seqlen_ctl[6:4]};
    if (seq_len == 4'h0) begin
      seq_len = 4'h8;
    end
  end

  adcsq_conv_timer u_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_run(state == adcsq_pkg::ST_CONV && !wr_start && !wr_abort),
    .o_step(step)
  );
  assign o_conv_step = step;
  assign seq_end = step && (done_in_seq == seq_len - 4'h1);

  // sequencer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state <= adcsq_pkg::ST_IDLE;
      chan <= 4'h0;
      done_in_seq <= 4'h0;
    end else if (!o_powered) begin
      state <= adcsq_pkg::ST_IDLE;
    end else if (wr_start) begin
      state <= adcsq_pkg::ST_CONV;
      chan <= wdata[3:0];
      done_in_seq <= 4'h0;
    end else if (wr_abort) begin
      state <= adcsq_pkg::ST_IDLE;
    end else begin
      case (state)
        adcsq_pkg::ST_IDLE: begin
        end
        adcsq_pkg::ST_CONV: begin
          if (step) begin
            if (start_ctl[adcsq_pkg::MULTI_BIT]) begin
              chan <= chan + 4'h1;
            end
            if (seq_end) begin
              done_in_seq <= 4'h0;
              if (!start_ctl[adcsq_pkg::SCAN_BIT]) begin
                state <= adcsq_pkg::ST_IDLE;
              end
            end else begin
              done_in_seq <= done_in_seq + 4'h1;
            end
          end
        end
        default: state <= adcsq_pkg::ST_IDLE;
      endcase
    end
  end
  assign o_busy = (state == adcsq_pkg::ST_CONV);
  assign o_channel = chan;
  assign o_justify = start_ctl[adcsq_pkg::JUSTIFY_BIT];
  assign o_signed = start_ctl[adcsq_pkg::SIGN_BIT];

  logic scf_clr;
  assign scf_clr = wr_en && i_address == adcsq_pkg::REG_STAT0 && wdata[adcsq_pkg::SCF_BIT];

  // completion flags; set wins over clear
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sequence_complete_flag <= 1'b0;
    end else if (seq_end && o_powered) begin
      sequence_complete_flag <= 1'b1;
    end else if (scf_clr) begin
      sequence_complete_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ccf <= 16'h0000;
      conv_count <= 4'h0;
    end else if (wr_start && o_powered) begin
      ccf <= 16'h0000;
      conv_count <= 4'h0;
    end else if (step && o_powered && !wr_abort) begin
      ccf[chan] <= 1'b1;
      conv_count <= done_in_seq;
    end
  end

  // sticky event bits: 0 sequence end, 1 abort, 2 start
  logic [2:0] events;
  assign events = {wr_start && o_powered, wr_abort && o_busy, seq_end && o_powered};
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      irq_stat <= 3'h0;
      irq_en <= 3'h0;
    end else begin
      if (wr_en && i_address == adcsq_pkg::REG_IRQ_EN) begin
        irq_en <= wdata[2:0];
      end
      if (wr_en && i_address == adcsq_pkg::REG_IRQ_CLR) begin
        irq_stat <= (irq_stat & ~wdata[2:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
    end
  end
  assign o_irq = (sequence_complete_flag && pwr_ctl[adcsq_pkg::SEQ_IRQ_EN_BIT]) || |(irq_stat & irq_en);

  // read mux
  always_comb begin
    next_rbyte = 8'h00;
    case (i_address)
      adcsq_pkg::REG_WRAP: next_rbyte = wrap_ctl;
      adcsq_pkg::REG_TRIG: next_rbyte = trig_ctl;
      adcsq_pkg::REG_PWR: next_rbyte = pwr_ctl | {7'h00, sequence_complete_flag};
      adcsq_pkg::REG_SEQLEN: next_rbyte = seqlen_ctl;
      adcsq_pkg::REG_TIMING: next_rbyte = timing_ctl;
      adcsq_pkg::REG_START: next_rbyte = start_ctl;
      adcsq_pkg::REG_STAT0: next_rbyte = {sequence_complete_flag, 3'h0, conv_count};
      adcsq_pkg::REG_TEST1: next_rbyte = {7'h00, test1};
      adcsq_pkg::REG_CCF_HI: next_rbyte = ccf[15:8];
      adcsq_pkg::REG_CCF_LO: next_rbyte = ccf[7:0];
      adcsq_pkg::REG_DIEN_HI: next_rbyte = dien_hi;
      adcsq_pkg::REG_IRQ_STAT: next_rbyte = {5'h00, irq_stat};
      adcsq_pkg::REG_IRQ_EN: next_rbyte = {5'h00, irq_en};
      default: next_rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_readdata <= 32'h00000000;
    end else if (i_read && !ack) begin
      o_readdata <= {24'h000000, next_rbyte};
    end
  end

  start_launch_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_start && o_powered |=> o_busy && ccf == 16'h0000) else $error("start did not launch");
  abort_stop_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_abort && !wr_start |=> !o_busy) else $error("abort did not stop");
  scf_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    scf_clr && !seq_end |=> !sequence_complete_flag) else $error("flag not cleared");
  scf_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    seq_end && o_powered |=> sequence_complete_flag) else $error("flag not set");
  power_down_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_powered |=> !o_busy) else $error("busy while off");
  reset_state_a: assert property (@(posedge i_clk)
    !i_nrst |=> !o_powered && !o_busy && !o_irq) else $error("bad reset state");
  chan_step_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    step && o_busy && start_ctl[adcsq_pkg::MULTI_BIT] && !wr_start && o_powered
    |=> o_channel == $past(o_channel) + 4'h1) else $error("channel not ascending");
  mode_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_start |=> start_ctl == $past(wdata)) else $error("start register not held");
  irq_level_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    sequence_complete_flag && pwr_ctl[adcsq_pkg::SEQ_IRQ_EN_BIT] |-> o_irq) else $error("irq missing");
  rsvd_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_read && !ack && i_address == adcsq_pkg::REG_GAP |=> o_readdata == 32'h00000000)
    else $error("reserved reads nonzero");
endmodule // adcsq_top

//--- pkg/adcsq_pkg.sv
/*
  Package for the converter sequence control block: register indices, field positions, reset values, timing counts.
  Assumes a 32-bit Avalon-MM slave with word address index = byte offset / 4.
*/
package adcsq_pkg;
  // register indices (byte address = index * 4)
  localparam logic [3:0] REG_WRAP = 4'h0;
  localparam logic [3:0] REG_TRIG = 4'h1;
  localparam logic [3:0] REG_PWR = 4'h2;
  localparam logic [3:0] REG_SEQLEN = 4'h3;
  localparam logic [3:0] REG_TIMING = 4'h4;
  localparam logic [3:0] REG_START = 4'h5;
  localparam logic [3:0] REG_STAT0 = 4'h6;
  localparam logic [3:0] REG_GAP = 4'h7;
  localparam logic [3:0] REG_TEST0 = 4'h8;
  localparam logic [3:0] REG_TEST1 = 4'h9;
  localparam logic [3:0] REG_CCF_HI = 4'hA;
  localparam logic [3:0] REG_CCF_LO = 4'hB;
  localparam logic [3:0] REG_DIEN_HI = 4'hC;
  localparam logic [3:0] REG_IRQ_STAT = 4'hD;
  localparam logic [3:0] REG_IRQ_EN = 4'hE;
  localparam logic [3:0] REG_IRQ_CLR = 4'hF;
  // power_irq_control fields
  localparam int PWR_UP_BIT = 7;
  localparam int SEQ_IRQ_EN_BIT = 1;
  localparam int SEQ_IRQ_FLAG_BIT = 0;
  // conversion_start_control fields
  localparam int JUSTIFY_BIT = 7;
  localparam int SIGN_BIT = 6;
  localparam int SCAN_BIT = 5;
  localparam int MULTI_BIT = 4;
  // sequence_status_zero fields
  localparam int SCF_BIT = 7;
  localparam int TRIG_OVR_BIT = 5;
  localparam int FIFO_OVR_BIT = 4;
  // field masks of writable bits
  localparam logic [7:0] WRAP_MASK = 8'h0F;
  localparam logic [7:0] TRIG_MASK = 8'h8F;
  localparam logic [7:0] PWR_MASK = 8'hFE;
  localparam logic [7:0] SEQLEN_MASK = 8'h7F;
  localparam logic [7:0] TEST1_MASK = 8'h01;
  // reset values
  localparam logic [7:0] WRAP_RST = 8'h0F;
  localparam logic [7:0] SEQLEN_RST = 8'h20;
  localparam logic [7:0] TIMING_RST = 8'h05;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // one conversion time, a stand-in for the analog step
  localparam int CONV_TIME_NS = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } adcsq_state_e;
endpackage

//--- tb/adcsq_analog_model.sv
/*
  Analog input side: samples the channel under conversion at each finished step.
  Assumes the channel output still shows the finished channel in the step cycle.
*/
`timescale 1ns/100ps
module adcsq_analog_model (
  // clock
  input wire logic i_clk,
  // converter side
  input wire logic i_step,
  input wire logic [3:0] i_channel,
  output logic o_done,
  output logic [3:0] o_ch
);
  always_ff @(posedge i_clk) begin
    o_done <= i_step;
    o_ch <= i_channel;
  end
endmodule // adcsq_analog_model

//--- tb/testbench.sv
/*
  Self-checking bench for the converter sequence control block.
  Assumes one 100 MHz clock; Avalon requests wait on waitrequest, bounded by a timeout.
*/
`timescale 1ns/100ps
module testbench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] i_address = 4'h0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest, o_powered, o_busy, o_conv_step, o_justify, o_signed, o_irq, ch_done;
  logic [3:0] o_channel, ch_seen;
  logic [7:0] st;
  logic [31:0] exp_rd [$];
  logic [3:0] exp_ch [$];
  logic [31:0] seed = 32'h00012D06;
  int error_cnt = 0;
  int comparisons = 0;
  initial forever #5 i_clk = ~i_clk;
  adcsq_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_powered(o_powered), .o_busy(o_busy), .o_channel(o_channel), .o_conv_step(o_conv_step),
    .o_justify(o_justify), .o_signed(o_signed), .o_irq(o_irq));
  adcsq_analog_model u_model (.i_clk(i_clk), .i_step(o_conv_step), .i_channel(o_channel),
    .o_done(ch_done), .o_ch(ch_seen));
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one request; a fresh edge first so back-to-back calls never drive twice in a step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_write <= wr;
    i_read <= ~wr;
    // waitrequest looked at on rising edges only; request stands until it is low
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        conclude();
      end
      @(posedge i_clk);
    end
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_rd.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge i_clk);
    while (o_busy !== 1'b0) begin
      n++;
      if (n > 300) begin
        error_cnt++;
        conclude();
      end
      @(negedge i_clk);
    end
  endtask
  // results are compared in the order they were noted
  always @(posedge i_clk) begin
    if (i_read === 1'b1 && o_waitrequest === 1'b0) check("readdata", o_readdata, exp_rd.pop_front());
    if (ch_done === 1'b1) check("channel", 32'(ch_seen), 32'(exp_ch.pop_front()));
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], a == 0 ? adcsq_pkg::WRAP_RST : a == 3 ? adcsq_pkg::SEQLEN_RST :
        a == 4 ? adcsq_pkg::TIMING_RST : adcsq_pkg::BYTE_RST);
    end
    check("powered", 32'(o_powered), 32'h0);
    $display("test reset done");
    wr(adcsq_pkg::REG_WRAP, 8'hFF);
    rd(adcsq_pkg::REG_WRAP, adcsq_pkg::WRAP_MASK);
    wr(adcsq_pkg::REG_TEST0, 8'hFF);
    rd(adcsq_pkg::REG_TEST0, 8'h00);
    // unpowered converter must not start
    wr(adcsq_pkg::REG_START, 8'h10);
    @(negedge i_clk);
    check("busy off", 32'(o_busy), 32'h0);
    $display("test reserved done");
    seed = xorshift(seed);
    st = {4'hD, seed[3:0]};
    wr(adcsq_pkg::REG_PWR, 8'h82);
    wr(adcsq_pkg::REG_SEQLEN, 8'h40);
    for (int k = 0; k < 4; k++) exp_ch.push_back(seed[3:0] + 4'(k));
    wr(adcsq_pkg::REG_START, st);
    @(negedge i_clk);
    check("busy", 32'(o_busy), 32'h1);
    check("fmt", {30'h0, o_justify, o_signed}, 32'h3);
    check("start ch", 32'(o_channel), 32'(seed[3:0]));
    wait_idle();
    check("irq", 32'(o_irq), 32'h1);
    rd(adcsq_pkg::REG_PWR, 8'h83);
    rd(adcsq_pkg::REG_IRQ_STAT, 8'h05);
    check("left", exp_ch.size(), 32'h0);
    $display("test sequence done");
    wr(adcsq_pkg::REG_PWR, 8'h80);
    @(negedge i_clk);
    check("irq mask", 32'(o_irq), 32'h0);
    wr(adcsq_pkg::REG_IRQ_EN, 8'h01);
    @(negedge i_clk);
    check("irq en", 32'(o_irq), 32'h1);
    wr(adcsq_pkg::REG_IRQ_CLR, 8'h01);
    @(negedge i_clk);
    check("irq clr", 32'(o_irq), 32'h0);
    rd(adcsq_pkg::REG_IRQ_STAT, 8'h04);
    wr(adcsq_pkg::REG_PWR, 8'h82);
    wr(adcsq_pkg::REG_STAT0, 8'h80);
    @(negedge i_clk);
    check("irq scf", 32'(o_irq), 32'h0);
    rd(adcsq_pkg::REG_PWR, 8'h82);
    $display("test interrupt done");
    wr(adcsq_pkg::REG_SEQLEN, 8'h10);
    repeat (2) exp_ch.push_back(4'h9);
    // continuous single-channel run: one step per pass, never idles by itself
    wr(adcsq_pkg::REG_START, 8'h29);
    repeat (45) @(negedge i_clk);
    check("scan", 32'(o_busy), 32'h1);
    check("scan left", exp_ch.size(), 32'h0);
    wr(adcsq_pkg::REG_TIMING, adcsq_pkg::TIMING_RST);
    @(negedge i_clk);
    check("abort", 32'(o_busy), 32'h0);
    wr(adcsq_pkg::REG_PWR, 8'h80);
    wr(adcsq_pkg::REG_STAT0, 8'h80);
    rd(adcsq_pkg::REG_IRQ_STAT, 8'h07);
    wr(adcsq_pkg::REG_IRQ_CLR, 8'h07);
    wr(adcsq_pkg::REG_PWR, 8'h00);
    @(negedge i_clk);
    check("power down", {30'h0, o_powered, o_irq}, 32'h0);
    $display("test abort done");
    conclude();
  end
endmodule // testbench
